// file: design/dsa_pkg.sv
// constants for the dual-slope converter control block
//
// Contract
// - Writing one to the run bit clears the converter state and starts a new conversion.
// - The result is a 13-bit magnitude count plus a separate polarity sign bit.
// - The readout-invalid bit reads one when the count just read is not valid, zero when valid.
// - At the end of reverse integration the done flag sets and an interrupt is requested if enabled.
// - The done interrupt enable bit blocks the request at zero and allows it at one.
// - The done flag sets regardless of the enable and clears as a side effect of being read.
// - Reset or switch-off may spuriously set the done flag, so software reads it then to clear it.
// - The resolution select picks full scale and time: code 00 longest, each higher code halves; code 11 here gives 820 counts, not 819.
// - The ground drive field selects external ground at 00, or internal drive x1, x2, x4.
package dsa_pkg;
  localparam logic [7:0] DONE_FLAG_ADDR  = 8'hc4;
  localparam logic [7:0] IRQ_EN_ADDR     = 8'hc8;
  localparam logic [7:0] GND_REF_ADDR    = 8'hf0;
  localparam logic [7:0] RES_SEL_ADDR    = 8'hf3;
  localparam logic [7:0] IN_MODE_ADDR    = 8'hf4;
  localparam logic [7:0] AIN_EN_ADDR     = 8'hf5;
  localparam logic [7:0] RUN_CTRL_ADDR   = 8'hf6;
  localparam logic [7:0] CNT0_ADDR       = 8'hf7;
  localparam logic [7:0] CNT1_ADDR       = 8'hf8;
  localparam logic [7:0] CNT2_ADDR       = 8'hf9;
  localparam logic [7:0] CNT3_ADDR       = 8'hfa;
  localparam logic [7:0] INVALID_ADDR    = 8'hfb;
  localparam int         DONE_FLAG_BIT   = 0;
  localparam int         IRQ_EN_BIT      = 2;
  localparam int         RUN_BIT         = 3;
  localparam int         AIN4_BIT        = 0;
  localparam int         SIGN_BIT        = 1;
  localparam int         COUNT_W         = 13;
  localparam logic [3:0] NIBBLE_RESET    = 4'h0;
  localparam logic [12:0] FULL_SCALE_MAX = 13'h1998; // 6552 counts
  localparam logic [12:0] FULL_SCALE_MIN = 13'h0334; // 820 counts
  localparam int         RAMP_MULT       = 2;   // reference phase vs full scale
  localparam int         STEP_DIV        = 8;   // clocks per count step
  typedef enum logic [1:0] {
    DSA_IDLE,
    DSA_FORWARD,
    DSA_REVERSE
  } dsa_state_t;
endpackage

// file: design/dsa_step_div.sv
// divider producing the count step enable
`timescale 1ns/10ps
module dsa_step_div #(
  parameter int DIV = dsa_pkg::STEP_DIV
) (
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  input  wire logic clear_i,
  output logic      step_o
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         next_step;

  always_comb begin
    next_step = 1'b0;
    next_cnt  = cnt + 1'b1;
    if (clear_i) begin
      next_cnt = '0;
    end else if (cnt == W'(DIV - 1)) begin
      next_cnt  = '0;
      next_step = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt    <= '0;
      step_o <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      step_o <= next_step;
    end
  end
endmodule

// file: design/dsa_ctrl.sv
// dual-slope converter sequencer and register file
`timescale 1ns/10ps
module dsa_ctrl #(
  parameter int STEP_DIV = dsa_pkg::STEP_DIV
) (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [3:0]  wdata_i,
  output logic      [3:0]  rdata_o,
  input  wire logic        comparator_i,
  input  wire logic        polarity_i,
  output logic             irq_o,
  output logic             integrate_o,
  output logic             reverse_o,
  output logic      [1:0]  ground_drive_o,
  output logic      [1:0]  vref_ctrl_o,
  output logic      [3:0]  input_mode_o,
  output logic      [4:0]  analog_input_enable_o,
  output logic      [1:0]  resolution_o
);
  // configuration, result and sequencer registers
  logic [3:0]  gnd_ref;
  logic [1:0]  res_sel;
  logic [3:0]  in_mode;
  logic [4:0]  ain_en;
  logic        converter_run;
  logic        done_irq_en;
  logic        convert_done_flag;
  logic [12:0] conversion_count;
  logic        polarity_sign;
  logic        readout_invalid;
  logic [12:0] counter;
  dsa_pkg::dsa_state_t state;

  logic [3:0]  next_gnd_ref;
  logic [1:0]  next_res_sel;
  logic [3:0]  next_in_mode;
  logic [4:0]  next_ain_en;
  logic        next_converter_run;
  logic        next_done_irq_en;
  logic        next_convert_done_flag;
  logic [12:0] next_conversion_count;
  logic        next_polarity_sign;
  logic        next_readout_invalid;
  logic [12:0] next_counter;
  dsa_pkg::dsa_state_t next_state;
  logic [3:0]  next_rdata;
  logic        next_irq;

  logic        step;
  logic        run_start;
  logic        reverse_end;
  logic [12:0] full_scale;

  assign run_start = wr_i && addr_i == dsa_pkg::RUN_CTRL_ADDR
                     && wdata_i[dsa_pkg::RUN_BIT];
  // halving per code keeps the count step fixed; the top code is one over
  assign full_scale = (res_sel == 2'h3) ? dsa_pkg::FULL_SCALE_MIN
                      : dsa_pkg::FULL_SCALE_MAX >> res_sel;
  assign reverse_end = state == dsa_pkg::DSA_REVERSE && step
                       && (comparator_i || counter == full_scale);

  dsa_step_div #(
    .DIV (STEP_DIV)
  ) u_div (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .clear_i   (run_start),
    .step_o    (step)
  );

  // register writes
  always_comb begin
    next_gnd_ref       = gnd_ref;
    next_res_sel       = res_sel;
    next_in_mode       = in_mode;
    next_ain_en        = ain_en;
    next_converter_run = converter_run;
    next_done_irq_en   = done_irq_en;
    if (wr_i) begin
      unique case (addr_i)
        dsa_pkg::GND_REF_ADDR: next_gnd_ref = wdata_i;
        dsa_pkg::RES_SEL_ADDR: next_res_sel = wdata_i[1:0];
        dsa_pkg::IN_MODE_ADDR: next_in_mode = wdata_i;
        dsa_pkg::AIN_EN_ADDR:  next_ain_en[3:0] = wdata_i;
        dsa_pkg::RUN_CTRL_ADDR: begin
          next_converter_run = wdata_i[dsa_pkg::RUN_BIT];
          next_ain_en[4]     = wdata_i[dsa_pkg::AIN4_BIT];
        end
        dsa_pkg::IRQ_EN_ADDR:
          next_done_irq_en = wdata_i[dsa_pkg::IRQ_EN_BIT];
        default: ;
      endcase
    end
  end

  // sequencer: forward over full scale, then reverse until comparator trips or full scale is reached
  always_comb begin
    next_state            = state;
    next_counter          = counter;
    next_conversion_count = conversion_count;
    next_polarity_sign    = polarity_sign;
    next_readout_invalid  = readout_invalid;
    if (run_start) begin
      next_state            = dsa_pkg::DSA_FORWARD;
      next_counter          = '0;
      next_conversion_count = '0;
      next_polarity_sign    = 1'b0;
      next_readout_invalid  = 1'b0;
    end else if (!converter_run) begin
      next_state = dsa_pkg::DSA_IDLE;
    end else if (step) begin
      unique case (state)
        dsa_pkg::DSA_IDLE: ;
        dsa_pkg::DSA_FORWARD: begin
          if (counter == full_scale) begin
            next_state         = dsa_pkg::DSA_REVERSE;
            next_counter       = '0;
            next_polarity_sign = polarity_i;
          end else begin
            next_counter = counter + 13'h0001;
          end
        end
        dsa_pkg::DSA_REVERSE: begin
          if (reverse_end) begin
            next_conversion_count = counter;
            // no comparator trip within full scale means over range
            next_readout_invalid  = !comparator_i;
            next_state            = dsa_pkg::DSA_FORWARD;
            next_counter          = '0;
          end else begin
            next_counter = counter + 13'h0001;
          end
        end
      endcase
    end
  end

  // done flag: a set in the read cycle wins over the clear
  always_comb begin
    next_convert_done_flag = convert_done_flag;
    if (rd_i && addr_i == dsa_pkg::DONE_FLAG_ADDR) begin
      next_convert_done_flag = 1'b0;
    end
    if (reverse_end && !run_start && converter_run) begin
      next_convert_done_flag = 1'b1;
    end
    next_irq = next_convert_done_flag && next_done_irq_en;
  end

  // read mux, registered
  always_comb begin
    next_rdata = 4'h0;
    if (rd_i) begin
      unique case (addr_i)
        dsa_pkg::DONE_FLAG_ADDR: next_rdata = {3'h0, convert_done_flag};
        dsa_pkg::IRQ_EN_ADDR:
          next_rdata = {1'b0, done_irq_en, 2'h0};
        dsa_pkg::GND_REF_ADDR:  next_rdata = gnd_ref;
        dsa_pkg::RES_SEL_ADDR:  next_rdata = {2'h0, res_sel};
        dsa_pkg::IN_MODE_ADDR:  next_rdata = in_mode;
        dsa_pkg::AIN_EN_ADDR:   next_rdata = ain_en[3:0];
        dsa_pkg::RUN_CTRL_ADDR:
          next_rdata = {converter_run, 2'h0, ain_en[4]};
        dsa_pkg::CNT0_ADDR: next_rdata = conversion_count[3:0];
        dsa_pkg::CNT1_ADDR: next_rdata = conversion_count[7:4];
        dsa_pkg::CNT2_ADDR: next_rdata = conversion_count[11:8];
        dsa_pkg::CNT3_ADDR:
          next_rdata = {2'h0, polarity_sign, conversion_count[12]};
        dsa_pkg::INVALID_ADDR: next_rdata = {3'h0, readout_invalid};
        default: next_rdata = 4'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      gnd_ref               <= dsa_pkg::NIBBLE_RESET;
      res_sel               <= 2'h0;
      in_mode               <= dsa_pkg::NIBBLE_RESET;
      ain_en                <= 5'h00;
      converter_run         <= 1'b0;
      done_irq_en           <= 1'b0;
      convert_done_flag     <= 1'b0;
      conversion_count      <= 13'h0000;
      polarity_sign         <= 1'b0;
      readout_invalid       <= 1'b0;
      counter               <= 13'h0000;
      state                 <= dsa_pkg::DSA_IDLE;
      rdata_o               <= 4'h0;
      irq_o                 <= 1'b0;
      integrate_o           <= 1'b0;
      reverse_o             <= 1'b0;
      ground_drive_o        <= 2'h0;
      vref_ctrl_o           <= 2'h0;
      input_mode_o          <= 4'h0;
      analog_input_enable_o <= 5'h00;
      resolution_o          <= 2'h0;
    end else begin
      gnd_ref               <= next_gnd_ref;
      res_sel               <= next_res_sel;
      in_mode               <= next_in_mode;
      ain_en                <= next_ain_en;
      converter_run         <= next_converter_run;
      done_irq_en           <= next_done_irq_en;
      convert_done_flag     <= next_convert_done_flag;
      conversion_count      <= next_conversion_count;
      polarity_sign         <= next_polarity_sign;
      readout_invalid       <= next_readout_invalid;
      counter               <= next_counter;
      state                 <= next_state;
      rdata_o               <= next_rdata;
      irq_o                 <= next_irq;
      integrate_o           <= next_state != dsa_pkg::DSA_IDLE;
      reverse_o             <= next_state == dsa_pkg::DSA_REVERSE;
      ground_drive_o        <= next_gnd_ref[3:2];
      vref_ctrl_o           <= next_gnd_ref[1:0];
      input_mode_o          <= next_in_mode;
      analog_input_enable_o <= next_ain_en;
      resolution_o          <= next_res_sel;
    end
  end
endmodule

// file: tb/dsa_ctrl_props.sv
// port checker for the converter control block
`timescale 1ns/10ps
module dsa_ctrl_props #(
  parameter int STEP_DIV = 8
) (
  input wire logic       ref_clk_i,
  input wire logic       reset_i,
  input wire logic [7:0] addr_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [3:0] wdata_i,
  input wire logic [3:0] rdata_o,
  input wire logic       irq_o,
  input wire logic       integrate_o,
  input wire logic       reverse_o,
  input wire logic [1:0] ground_drive_o,
  input wire logic [1:0] resolution_o
);
  logic [1:0] wd_hi;
  logic [1:0] wd_lo;
  assign wd_hi = wdata_i[3:2];
  assign wd_lo = wdata_i[1:0];
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  AST_RUN_GO: assert property (
    wr_i && addr_i == dsa_pkg::RUN_CTRL_ADDR && wdata_i[3]
    |-> ##[1:2] (integrate_o && !reverse_o)) else $error("run did not start");
  AST_RUN_OFF: assert property (
    wr_i && addr_i == dsa_pkg::RUN_CTRL_ADDR && !wdata_i[3]
    |-> ##2 !integrate_o [*3]) else $error("converter did not stop");
  AST_RES_COPY: assert property (
    wr_i && addr_i == dsa_pkg::RES_SEL_ADDR
    |-> ##2 resolution_o == $past(wd_lo, 2)) else $error("resolution copy");
  AST_GND_COPY: assert property (
    wr_i && addr_i == dsa_pkg::GND_REF_ADDR
    |-> ##2 ground_drive_o == $past(wd_hi, 2)) else $error("ground copy");
  AST_RES_UNUSED: assert property (
    rd_i && addr_i == dsa_pkg::RES_SEL_ADDR
    |=> rdata_o[3:2] == 2'h0) else $error("resolution upper bits set");
  AST_SIGN_NIB: assert property (
    rd_i && addr_i == dsa_pkg::CNT3_ADDR
    |=> rdata_o[3:2] == 2'h0) else $error("top nibble upper bits set");
  AST_INV_NIB: assert property (
    rd_i && addr_i == dsa_pkg::INVALID_ADDR
    |=> rdata_o[3:1] == 3'h0) else $error("status upper bits set");
  AST_FLAG_NIB: assert property (
    rd_i && addr_i == dsa_pkg::DONE_FLAG_ADDR
    |=> rdata_o[3:1] == 3'h0) else $error("flag upper bits set");
  AST_IRQ_MASK: assert property (
    wr_i && addr_i == dsa_pkg::IRQ_EN_ADDR && !wdata_i[2]
    |-> ##2 !irq_o [*3]) else $error("masked request seen");
  AST_IDLE_READ: assert property (
    !rd_i |=> rdata_o == 4'h0) else $error("read data without read");
  cover property ($fell(reverse_o));
  cover property ($rose(irq_o));
  cover property (rd_i && addr_i == dsa_pkg::DONE_FLAG_ADDR);
endmodule
bind dsa_ctrl dsa_ctrl_props #(
  .STEP_DIV (STEP_DIV)
) u_props (
  .ref_clk_i      (ref_clk_i),
  .reset_i        (reset_i),
  .addr_i         (addr_i),
  .wr_i           (wr_i),
  .rd_i           (rd_i),
  .wdata_i        (wdata_i),
  .rdata_o        (rdata_o),
  .irq_o          (irq_o),
  .integrate_o    (integrate_o),
  .reverse_o      (reverse_o),
  .ground_drive_o (ground_drive_o),
  .resolution_o   (resolution_o)
);

// file: tb/dsa_afe_model.sv
// integrator stand-in: comparator trips after a set reverse time
`timescale 1ns/10ps
module dsa_afe_model (
  input  wire logic ref_clk_i,
  input  wire logic reverse_i,
  input  wire logic [31:0] trip_i,
  input  wire logic sign_i,
  output logic      comparator_o,
  output logic      polarity_o
);
  int rev_cnt;
  always_ff @(posedge ref_clk_i) begin
    rev_cnt <= reverse_i ? rev_cnt + 1 : 0;
  end
  // trip 0 stands for an input beyond full scale
  assign comparator_o = reverse_i && trip_i != 0 && rev_cnt >= trip_i;
  assign polarity_o = sign_i;
endmodule

// file: tb/tb_dsa_ctrl.sv
// self-checking bench for the converter control block
`timescale 1ns/10ps
module tb_dsa_ctrl;
  logic        ref_clk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0, sign = 0;
  logic [7:0]  addr_i = 8'h00;
  logic [3:0]  wdata_i = 4'h0, rdata_o, rv, inv;
  logic        irq_o, integrate_o, reverse_o, comparator_i, polarity_i;
  logic [1:0]  ground_drive_o, vref_ctrl_o, resolution_o;
  logic [3:0]  input_mode_o;
  logic [4:0]  analog_input_enable_o;
  logic [15:0] cnt, held;
  logic [3:0]  wv [4];
  logic [7:0]  regs [13] = '{8'hc0, 8'hc4, 8'hc8, 8'hf0, 8'hf3, 8'hf4,
                             8'hf5, 8'hf6, 8'hf7, 8'hf8, 8'hf9, 8'hfa, 8'hfb};
  logic [7:0]  cfg [4] = '{8'hf0, 8'hf3, 8'hf4, 8'hf5};
  logic [3:0]  msk [4] = '{4'hf, 4'h3, 4'hf, 4'hf};
  int          trip = 0, miscompares = 0, checks_done = 0, fs;
  dsa_ctrl #(
    .STEP_DIV (1)
  ) dut (
    .ref_clk_i             (ref_clk_i),
    .reset_i               (reset_i),
    .addr_i                (addr_i),
    .wr_i                  (wr_i),
    .rd_i                  (rd_i),
    .wdata_i               (wdata_i),
    .rdata_o               (rdata_o),
    .comparator_i          (comparator_i),
    .polarity_i            (polarity_i),
    .irq_o                 (irq_o),
    .integrate_o           (integrate_o),
    .reverse_o             (reverse_o),
    .ground_drive_o        (ground_drive_o),
    .vref_ctrl_o           (vref_ctrl_o),
    .input_mode_o          (input_mode_o),
    .analog_input_enable_o (analog_input_enable_o),
    .resolution_o          (resolution_o)
  );
  dsa_afe_model afe (.ref_clk_i(ref_clk_i), .reverse_i(reverse_o),
    .trip_i(trip), .sign_i(sign), .comparator_o(comparator_i),
    .polarity_o(polarity_i));
  always #4 ref_clk_i = ~ref_clk_i;
  task automatic cmp(string nm, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(logic [7:0] a, logic [3:0] d, logic w);
    @(negedge ref_clk_i);
    addr_i = a;
    wdata_i = d;
    wr_i = w;
    rd_i = !w;
    @(negedge ref_clk_i);
    wr_i = 0;
    rd_i = 0;
    rv = rdata_o;
  endtask
  task automatic conv_end();
    repeat (14000) if (reverse_o !== 1'b1) @(negedge ref_clk_i);
    repeat (14000) if (reverse_o !== 1'b0) @(negedge ref_clk_i);
    repeat (3) @(negedge ref_clk_i);
  endtask
  // nibbles lowest first, status straight after
  task automatic read_res();
    bus(dsa_pkg::CNT0_ADDR, 4'h0, 0);
    cnt[3:0] = rv;
    bus(dsa_pkg::CNT1_ADDR, 4'h0, 0);
    cnt[7:4] = rv;
    bus(dsa_pkg::CNT2_ADDR, 4'h0, 0);
    cnt[11:8] = rv;
    bus(dsa_pkg::CNT3_ADDR, 4'h0, 0);
    cnt[15:12] = rv;
    bus(dsa_pkg::INVALID_ADDR, 4'h0, 0);
    inv = rv;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #(60000 * 8);
    miscompares++;
    wrap_up();
  end
  initial begin
    void'($urandom(94));
    repeat (2) @(negedge ref_clk_i);
    reset_i = 0;
    foreach (regs[i]) begin
      bus(regs[i], 4'h0, 0);
      cmp("reset_value", 16'h0, 16'(rv));
    end
    $display("test reset values done");
    foreach (cfg[i]) begin
      wv[i] = 4'($urandom);
      bus(cfg[i], wv[i], 1);
      bus(cfg[i], 4'h0, 0);
      cmp("config", 16'(wv[i] & msk[i]), 16'(rv));
    end
    cmp("ground_drive", 16'(wv[0][3:2]), 16'(ground_drive_o));
    cmp("vref_ctrl", 16'(wv[0][1:0]), 16'(vref_ctrl_o));
    cmp("resolution", 16'(wv[1][1:0]), 16'(resolution_o));
    cmp("input_mode", 16'(wv[2]), 16'(input_mode_o));
    cmp("ain_enable", 16'(wv[3]), 16'(analog_input_enable_o));
    bus(dsa_pkg::IN_MODE_ADDR, 4'h0, 1);
    bus(dsa_pkg::AIN_EN_ADDR, 4'h1, 1);
    bus(dsa_pkg::IRQ_EN_ADDR, 4'h0, 1);
    $display("test config done");
    for (int res = 0; res < 4; res++) begin
      fs = (res == 3) ? 820 : 6552 >> res;
      sign = 1'($urandom);
      bus(dsa_pkg::RES_SEL_ADDR, 4'(res), 1);
      bus(dsa_pkg::RUN_CTRL_ADDR, 4'h8, 1);
      bus(dsa_pkg::DONE_FLAG_ADDR, 4'h0, 0);
      conv_end();
      cmp("irq_masked", 16'h0, 16'(irq_o));
      read_res();
      cmp("count", {2'h0, sign, 13'(fs)}, cnt);
      cmp("invalid", 16'h1, 16'(inv));
      bus(dsa_pkg::DONE_FLAG_ADDR, 4'h0, 0);
      cmp("done_flag", 16'h1, 16'(rv));
    end
    $display("test full scale done");
    bus(dsa_pkg::RES_SEL_ADDR, 4'h3, 1);
    bus(dsa_pkg::IRQ_EN_ADDR, 4'h4, 1);
    trip = 100 + $urandom % 600;
    sign = 1'($urandom);
    bus(dsa_pkg::RUN_CTRL_ADDR, 4'h8, 1);
    bus(dsa_pkg::DONE_FLAG_ADDR, 4'h0, 0);
    conv_end();
    cmp("irq", 16'h1, 16'(irq_o));
    read_res();
    cmp("count_near", 16'h1,
        16'(int'(cnt[12:0]) >= trip - 2 && int'(cnt[12:0]) <= trip + 2));
    cmp("sign", 16'(sign), 16'(cnt[13]));
    cmp("invalid", 16'h0, 16'(inv));
    bus(dsa_pkg::DONE_FLAG_ADDR, 4'h0, 0);
    cmp("done_flag", 16'h1, 16'(rv));
    @(negedge ref_clk_i);
    cmp("irq_cleared", 16'h0, 16'(irq_o));
    bus(dsa_pkg::DONE_FLAG_ADDR, 4'h0, 0);
    cmp("flag_cleared", 16'h0, 16'(rv));
    held = cnt;
    bus(dsa_pkg::RUN_CTRL_ADDR, 4'h0, 1);
    bus(dsa_pkg::DONE_FLAG_ADDR, 4'h0, 0);
    cmp("stopped", 16'h0, 16'(integrate_o));
    read_res();
    cmp("held_count", held, cnt);
    cmp("held_invalid", 16'h0, 16'(inv));
    $display("test conversion done");
    wrap_up();
  end
endmodule
